// >>> core/isq_defines.svh
`ifndef ISQ_DEFINES_SVH
`define ISQ_DEFINES_SVH

`define ISQ_PC_W        11
`define ISQ_PC_RESET    11'h000
`define ISQ_STACK_DEPTH 6
`define ISQ_PHASES      4

`define ISQ_OFF_PCL     4'h0
`define ISQ_OFF_ACC     4'h4
`define ISQ_OFF_STATUS  4'h8
`define ISQ_OFF_CTRL    4'hc

`define ISQ_CTRL_RUN_BIT 0
`define ISQ_CTRL_RESET   1'b1
`define ISQ_ACC_RESET    8'h00
`define ISQ_FLAGS_RESET  4'h0

`endif

// >>> core/isq_pkg.sv
`include "isq_defines.svh"
package isq_pkg;

  typedef enum logic [3:0] {
    ISQ_T1 = 4'h1,
    ISQ_T2 = 4'h2,
    ISQ_T3 = 4'h4,
    ISQ_T4 = 4'h8
  } isq_phase_t;

  typedef enum logic [2:0] {
    ISQ_K_NOP   = 3'h0,
    ISQ_K_ALU   = 3'h1,
    ISQ_K_JUMP  = 3'h2,
    ISQ_K_CALL  = 3'h3,
    ISQ_K_RET   = 3'h4,
    ISQ_K_RETURN_FROM_INTERRUPT  = 3'h5,
    ISQ_K_PCLWR = 3'h6
  } isq_kind_t;

  typedef enum logic [3:0] {
    ISQ_OP_ADD  = 4'h0,
    ISQ_OP_ADC  = 4'h1,
    ISQ_OP_SUB  = 4'h2,
    ISQ_OP_SBC  = 4'h3,
    ISQ_OP_DAA  = 4'h4,
    ISQ_OP_AND  = 4'h5,
    ISQ_OP_OR   = 4'h6,
    ISQ_OP_XOR  = 4'h7,
    ISQ_OP_CPL  = 4'h8,
    ISQ_OP_RR   = 4'h9,
    ISQ_OP_RRC  = 4'ha,
    ISQ_OP_RL   = 4'hb,
    ISQ_OP_RLC  = 4'hc,
    ISQ_OP_INC  = 4'hd,
    ISQ_OP_DEC  = 4'he,
    ISQ_OP_PASS = 4'hf
  } isq_alu_op_t;

  typedef enum logic [1:0] {
    ISQ_SK_NONE    = 2'h0,
    ISQ_SK_ZERO    = 2'h1,
    ISQ_SK_NONZERO = 2'h2
  } isq_skip_t;

  // decoded instruction as delivered by the fetch path
  typedef struct packed {
    isq_kind_t             kind;
    isq_alu_op_t           op;
    isq_skip_t             skip;
    logic                  use_acc;
    logic                  wb_en;
    logic                  to_mem;
    logic [`ISQ_PC_W-1:0]  target;
    logic [7:0]            operand;
  } isq_cmd_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } isq_flags_t;

  // upd mask follows isq_flags_t order {ov,z,ac,c}
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       ac;
    logic       ov;
    logic [3:0] upd;
  } isq_alu_res_t;

endpackage

// >>> core/isq_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "isq_defines.svh"
module isq_sequencer #(
  parameter int STACK_DEPTH = `ISQ_STACK_DEPTH
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  // avalon-mm register slave
  input  wire logic [3:0]             avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  // program memory fetch path
  output logic [`ISQ_PC_W-1:0]        fetch_addr_out,
  output logic                        fetch_req_out,
  input  wire isq_pkg::isq_cmd_t      fetch_cmd_in,
  // interrupt logic
  input  wire logic                   int_req_in,
  input  wire logic [`ISQ_PC_W-1:0]   int_vector_in,
  output logic                        int_ack_out,
  output logic                        int_return_out,
  // data memory write-back
  output logic [7:0]                  dmem_wdata_out,
  output logic                        dmem_we_out,
  // instruction phase clocks
  output logic [3:0]                  phase_out
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int IX_W = $clog2(STACK_DEPTH);
  localparam logic [SP_W-1:0] DEPTH_MAX = SP_W'(STACK_DEPTH);
  localparam logic [IX_W-1:0] IX_LAST = IX_W'(STACK_DEPTH - 1);
  localparam isq_pkg::isq_cmd_t NOP_CMD = '0;

  // 8-bit alu, one function for every class of operation
  function automatic isq_pkg::isq_alu_res_t isq_alu(
    input isq_pkg::isq_alu_op_t op,
    input logic [7:0]           a,
    input logic [7:0]           b,
    input logic                 cin,
    input logic                 acin
  );
    isq_pkg::isq_alu_res_t r;
    logic [8:0] sum;
    logic [8:0] adj;
    logic [4:0] nib;
    logic [7:0] bs;
    logic       ci;
    r   = '0;
    bs  = (op == isq_pkg::ISQ_OP_SUB || op == isq_pkg::ISQ_OP_SBC) ?
          ~b : b;
    ci  = (op == isq_pkg::ISQ_OP_SUB) ? 1'b1 :
          (op == isq_pkg::ISQ_OP_ADD) ? 1'b0 : cin;
    sum = {1'b0, a} + {1'b0, bs} + {8'h00, ci};
    nib = {1'b0, a[3:0]} + {1'b0, bs[3:0]} + {4'h0, ci};
    adj = {1'b0, a};
    if (a[3:0] > 4'h9 || acin) adj = adj + 9'h006;
    if (adj[7:4] > 4'h9 || cin || adj[8]) adj = adj + 9'h060;
    case (op)
      isq_pkg::ISQ_OP_ADD, isq_pkg::ISQ_OP_ADC,
      isq_pkg::ISQ_OP_SUB, isq_pkg::ISQ_OP_SBC: begin
        r.res = sum[7:0];
        r.c   = sum[8];  // on subtract: set means no borrow
        r.ac  = nib[4];
        r.ov  = (a[7] == bs[7]) && (sum[7] != a[7]);
        r.upd = 4'hf;
      end
      isq_pkg::ISQ_OP_DAA: begin
        r.res = adj[7:0];
        r.c   = adj[8] | cin;
        r.upd = 4'h1;
      end
      isq_pkg::ISQ_OP_AND: begin
        r.res = a & b;
        r.upd = 4'h4;
      end
      isq_pkg::ISQ_OP_OR: begin
        r.res = a | b;
        r.upd = 4'h4;
      end
      isq_pkg::ISQ_OP_XOR: begin
        r.res = a ^ b;
        r.upd = 4'h4;
      end
      isq_pkg::ISQ_OP_CPL: begin
        r.res = ~b;
        r.upd = 4'h4;
      end
      isq_pkg::ISQ_OP_RR:  r.res = {b[0], b[7:1]};
      isq_pkg::ISQ_OP_RRC: begin
        r.res = {cin, b[7:1]};
        r.c   = b[0];
        r.upd = 4'h1;
      end
      isq_pkg::ISQ_OP_RL:  r.res = {b[6:0], b[7]};
      isq_pkg::ISQ_OP_RLC: begin
        r.res = {b[6:0], cin};
        r.c   = b[7];
        r.upd = 4'h1;
      end
      isq_pkg::ISQ_OP_INC: begin
        r.res = b + 8'h01;
        r.upd = 4'h4;
      end
      isq_pkg::ISQ_OP_DEC: begin
        r.res = b - 8'h01;
        r.upd = 4'h4;
      end
      default: r.res = b;  // pass, used by plain skip tests
    endcase
    return r;
  endfunction

  isq_pkg::isq_phase_t   phase_r;
  isq_pkg::isq_cmd_t     fetched_r;
  isq_pkg::isq_cmd_t     exec_r;
  isq_pkg::isq_flags_t   flags_r;
  isq_pkg::isq_alu_res_t alu;
  logic [`ISQ_PC_W-1:0]  pc_r;
  logic [`ISQ_PC_W-1:0]  pc_nxt;
  logic [`ISQ_PC_W-1:0]  stack_mem [STACK_DEPTH];
  logic [`ISQ_PC_W-1:0]  stack_top;
  logic [SP_W-1:0]       depth_r;
  logic [IX_W-1:0]       wr_ix_r;
  logic [IX_W-1:0]       top_ix;
  logic [7:0]            acc_r;
  logic [7:0]            pcl_data_r;
  logic [7:0]            b_opnd;
  logic [31:0]           rdata_r;
  logic                  pcl_pend_r;
  logic                  run_r;
  logic                  ack_r;
  logic                  end_t4;
  logic                  res_zero;
  logic                  skip_take;
  logic                  stack_full;
  logic                  flush;
  logic                  push;
  logic                  pop;
  logic                  int_take;
  logic                  pcl_take;
  logic                  bus_req;
  logic                  bus_wr;

  assign end_t4     = run_r && phase_r == isq_pkg::ISQ_T4;
  assign stack_full = depth_r == DEPTH_MAX;
  assign top_ix     = (wr_ix_r == '0) ? IX_LAST : wr_ix_r - IX_W'(1);
  assign stack_top  = stack_mem[top_ix];
  assign b_opnd     = exec_r.use_acc ? acc_r : exec_r.operand;
  assign alu        = isq_alu(exec_r.op, acc_r, b_opnd, flags_r.c,
                              flags_r.ac);
  assign res_zero   = alu.res == 8'h00;
  assign skip_take  = exec_r.kind == isq_pkg::ISQ_K_ALU &&
                      ((exec_r.skip == isq_pkg::ISQ_SK_ZERO && res_zero) ||
                       (exec_r.skip == isq_pkg::ISQ_SK_NONZERO &&
                        !res_zero));

  // phase ring; holding it while stopped freezes the whole sequence
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_r <= isq_pkg::ISQ_T1;
    end else if (run_r) begin
      case (phase_r)
        isq_pkg::ISQ_T1: phase_r <= isq_pkg::ISQ_T2;
        isq_pkg::ISQ_T2: phase_r <= isq_pkg::ISQ_T3;
        isq_pkg::ISQ_T3: phase_r <= isq_pkg::ISQ_T4;
        isq_pkg::ISQ_T4: phase_r <= isq_pkg::ISQ_T1;
        default:         phase_r <= isq_pkg::ISQ_T1;
      endcase
    end
  end
  assign phase_out = phase_r;

  // flow decision for the instruction finishing in this cycle
  always_comb begin
    pc_nxt   = pc_r + `ISQ_PC_W'(1);
    flush    = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    int_take = 1'b0;
    pcl_take = 1'b0;
    case (exec_r.kind)
      isq_pkg::ISQ_K_JUMP: begin
        pc_nxt = exec_r.target;
        flush  = 1'b1;
      end
      isq_pkg::ISQ_K_CALL: begin
        pc_nxt = exec_r.target;
        flush  = 1'b1;
        push   = 1'b1;
      end
      isq_pkg::ISQ_K_RET, isq_pkg::ISQ_K_RETURN_FROM_INTERRUPT: begin
        pc_nxt = stack_top;
        flush  = 1'b1;
        pop    = 1'b1;
      end
      isq_pkg::ISQ_K_PCLWR: begin
        pc_nxt = {pc_r[`ISQ_PC_W-1:8], exec_r.operand};
        flush  = 1'b1;
      end
      default: begin
        if (skip_take) begin
          flush = 1'b1;
        end else if (pcl_pend_r) begin
          pcl_take = 1'b1;
          pc_nxt   = {pc_r[`ISQ_PC_W-1:8], pcl_data_r};
          flush    = 1'b1;
        end else if (int_req_in && !stack_full) begin
          int_take = 1'b1;
          push     = 1'b1;
          pc_nxt   = int_vector_in;
          flush    = 1'b1;
        end
      end
    endcase
  end

  // counter; its value during a cycle is the address being fetched
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_r <= `ISQ_PC_RESET;
    end else if (end_t4) begin
      pc_r <= pc_nxt;
    end
  end

  // fetch in the first phase, hand over to execute at cycle end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fetched_r <= NOP_CMD;
      exec_r    <= NOP_CMD;
    end else begin
      if (run_r && phase_r == isq_pkg::ISQ_T1) begin
        fetched_r <= fetch_cmd_in;
      end
      if (end_t4) begin
        exec_r <= flush ? NOP_CMD : fetched_r;
      end
    end
  end
  assign fetch_req_out  = run_r && phase_r == isq_pkg::ISQ_T1;
  assign fetch_addr_out = pc_r;

  // return stack; no port reaches it, so software cannot see it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      depth_r <= '0;
      wr_ix_r <= '0;
    end else if (end_t4 && push) begin
      stack_mem[wr_ix_r] <= pc_r;
      wr_ix_r <= (wr_ix_r == IX_LAST) ? '0 : wr_ix_r + IX_W'(1);
      if (!stack_full) depth_r <= depth_r + SP_W'(1);
    end else if (end_t4 && pop) begin
      wr_ix_r <= top_ix;
      if (depth_r != '0) depth_r <= depth_r - SP_W'(1);
    end
  end

  // acknowledge and return pulses toward the interrupt logic
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      int_ack_out    <= 1'b0;
      int_return_out <= 1'b0;
    end else begin
      int_ack_out    <= end_t4 && int_take;
      int_return_out <= end_t4 && exec_r.kind == isq_pkg::ISQ_K_RETURN_FROM_INTERRUPT;
    end
  end

  // alu write-back and flags; bus write to the accumulator wins
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_r          <= `ISQ_ACC_RESET;
      flags_r        <= `ISQ_FLAGS_RESET;
      dmem_wdata_out <= 8'h00;
      dmem_we_out    <= 1'b0;
    end else begin
      dmem_we_out <= 1'b0;
      if (end_t4 && exec_r.kind == isq_pkg::ISQ_K_ALU) begin
        if (exec_r.wb_en && exec_r.to_mem) begin
          dmem_wdata_out <= alu.res;
          dmem_we_out    <= 1'b1;
        end else if (exec_r.wb_en) begin
          acc_r <= alu.res;
        end
        if (alu.upd[0]) flags_r.c  <= alu.c;
        if (alu.upd[1]) flags_r.ac <= alu.ac;
        if (alu.upd[2]) flags_r.z  <= res_zero;
        if (alu.upd[3]) flags_r.ov <= alu.ov;
      end
      if (bus_wr && avs_address_in == `ISQ_OFF_ACC && avs_byteenable_in[0])
        acc_r <= avs_writedata_in[7:0];
    end
  end

  // avalon slave: one wait cycle, then readdata from a flop
  assign bus_req             = avs_read_in || avs_write_in;
  assign bus_wr              = avs_write_in && ack_r;
  assign avs_waitrequest_out = bus_req && !ack_r;
  assign avs_readdata_out    = rdata_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= bus_req && !ack_r;
      rdata_r <= 32'h0000_0000;  // unmapped offsets read zero
      case (avs_address_in)
        `ISQ_OFF_PCL:    rdata_r[7:0] <= pc_r[7:0];
        `ISQ_OFF_ACC:    rdata_r[7:0] <= acc_r;
        `ISQ_OFF_STATUS: rdata_r[3:0] <= flags_r;
        `ISQ_OFF_CTRL:   rdata_r[`ISQ_CTRL_RUN_BIT] <= run_r;
        default:         rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // control and queued page jump; a new write beats the consume
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_r      <= `ISQ_CTRL_RESET;
      pcl_pend_r <= 1'b0;
      pcl_data_r <= 8'h00;
    end else begin
      if (end_t4 && pcl_take) pcl_pend_r <= 1'b0;
      if (bus_wr && avs_byteenable_in[0]) begin
        if (avs_address_in == `ISQ_OFF_PCL) begin
          pcl_pend_r <= 1'b1;
          pcl_data_r <= avs_writedata_in[7:0];
        end
        if (avs_address_in == `ISQ_OFF_CTRL)
          run_r <= avs_writedata_in[`ISQ_CTRL_RUN_BIT];
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_end(isq_pkg::isq_kind_t k);
    end_t4 && exec_r.kind == k;
  endsequence
  sequence s_dummy_next;
    exec_r.kind == isq_pkg::ISQ_K_NOP;
  endsequence

  a_phase_walk: assert property (
    run_r && phase_r == isq_pkg::ISQ_T1 ##1 run_r[*3] |->
      phase_r == isq_pkg::ISQ_T4)
    else $error("phase ring did not reach last phase");
  a_fetch_slot: assert property (
    fetch_req_out |-> phase_r == isq_pkg::ISQ_T1 && fetch_addr_out == pc_r)
    else $error("fetch outside first phase");
  a_pc_step_one: assert property (
    end_t4 && !flush |=> pc_r == $past(pc_r) + `ISQ_PC_W'(1))
    else $error("counter did not step by one");
  a_jump_dummy: assert property (
    s_end(isq_pkg::ISQ_K_JUMP) |=>
      s_dummy_next and (pc_r == $past(exec_r.target)))
    else $error("jump missing target or dummy cycle");
  a_page_jump: assert property (
    s_end(isq_pkg::ISQ_K_PCLWR) |=>
      (pc_r[10:8] == $past(pc_r[10:8])) and s_dummy_next)
    else $error("low byte jump left the page");
  a_skip_drop: assert property (
    end_t4 && skip_take |=> s_dummy_next)
    else $error("taken skip kept fetched instruction");
  a_call_restore: assert property (
    s_end(isq_pkg::ISQ_K_CALL) ##8 s_end(isq_pkg::ISQ_K_RET) |=>
      pc_r == $past(pc_r, 9))
    else $error("return did not restore saved counter");
  a_full_no_ack: assert property (
    end_t4 && stack_full |=> !int_ack_out)
    else $error("interrupt acknowledged on full stack");
  a_overflow_full: assert property (
    s_end(isq_pkg::ISQ_K_CALL) and stack_full |=>
      stack_full and s_dummy_next)
    else $error("call on full stack misbehaved");
  a_bus_one_wait: assert property (
    bus_req && !ack_r |=> !avs_waitrequest_out)
    else $error("waitrequest held longer than one cycle");

endmodule
`default_nettype wire

// >>> verification/isq_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
module isq_fetch_model #(
  parameter logic [10:0] INT_VEC = 11'h300
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // program memory fetch path
  input  wire logic [10:0]       fetch_addr_in,
  input  wire logic              fetch_req_in,
  output isq_pkg::isq_cmd_t      fetch_cmd_out,
  // interrupt source
  input  wire logic              int_raise_in,
  input  wire logic              int_ack_in,
  output logic                   int_req_out,
  output logic [10:0]            int_vector_out
);
  isq_pkg::isq_cmd_t prog [0:2047];
  isq_pkg::isq_cmd_t last_r;

  // outside the fetch slot the path shows junk, never the old word
  always_comb begin
    if (fetch_req_in) begin
      fetch_cmd_out = prog[fetch_addr_in];
    end else begin
      fetch_cmd_out = isq_pkg::isq_cmd_t'(~last_r);
    end
  end

  // remember the last word handed out
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      last_r <= '0;
    end else if (fetch_req_in) begin
      last_r <= prog[fetch_addr_in];
    end
  end

  // request flag held until acknowledged, even while the stack is full
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      int_req_out <= 1'b0;
    end else if (int_ack_in) begin
      int_req_out <= 1'b0;
    end else if (int_raise_in) begin
      int_req_out <= 1'b1;
    end
  end

  // vector only meaningful while a request is pending
  assign int_vector_out = int_req_out ? INT_VEC : ~INT_VEC;
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // design-facing signals
  logic              clk_in           = 1'b0;
  logic              arst_n_in        = 1'b0;
  logic [3:0]        avs_address_in   = 4'h0;
  logic              avs_read_in      = 1'b0;
  logic              avs_write_in     = 1'b0;
  logic [31:0]       avs_writedata_in = 32'h0;
  logic [3:0]        avs_byteenable_in = 4'hf;
  logic [31:0]       avs_readdata_out;
  logic              avs_waitrequest_out;
  logic [10:0]       fetch_addr_out;
  logic              fetch_req_out;
  isq_pkg::isq_cmd_t fetch_cmd_in;
  logic              int_req_in;
  logic [10:0]       int_vector_in;
  logic              int_ack_out;
  logic              int_return_out;
  logic [7:0]        dmem_wdata_out;
  logic              dmem_we_out;
  logic [3:0]        phase_out;
  // bench bookkeeping
  logic              int_raise  = 1'b0;
  logic [10:0]       trace[$];
  logic [7:0]        last_wd;
  int                n_fail     = 0;
  int                n_compared = 0;
  int                n_ack      = 0;
  int                n_ret      = 0;
  int                n_we       = 0;
  localparam logic [10:0] VEC = 11'h300;

  // 10 mhz system clock
  always #50 clk_in = ~clk_in;

  isq_sequencer isq_sequencer_inst (
    .clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .fetch_addr_out, .fetch_req_out, .fetch_cmd_in,
    .int_req_in, .int_vector_in, .int_ack_out, .int_return_out,
    .dmem_wdata_out, .dmem_we_out, .phase_out
  );

  isq_fetch_model #(.INT_VEC(VEC)) isq_fetch_model_inst (
    .clk_in, .arst_n_in, .fetch_addr_in(fetch_addr_out),
    .fetch_req_in(fetch_req_out), .fetch_cmd_out(fetch_cmd_in),
    .int_raise_in(int_raise), .int_ack_in(int_ack_out),
    .int_req_out(int_req_in), .int_vector_out(int_vector_in)
  );

  // observe on the falling edge, clear of launch races
  always @(negedge clk_in) begin
    if (arst_n_in && phase_out === 4'h1 && fetch_req_out === 1'b1)
      trace.push_back(fetch_addr_out);
    if (int_ack_out === 1'b1) n_ack++;
    if (int_return_out === 1'b1) n_ret++;
    if (dmem_we_out === 1'b1) begin
      n_we++;
      last_wd = dmem_wdata_out;
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a wait that ran out ends the run as a mismatch
  task automatic bail(input string what);
    check(32'h1, 32'h0, what);
    end_of_test();
  endtask

  function automatic isq_pkg::isq_cmd_t mk(
      input isq_pkg::isq_kind_t   k,
      input logic [10:0]          t   = 11'h000,
      input isq_pkg::isq_alu_op_t op  = isq_pkg::ISQ_OP_ADD,
      input isq_pkg::isq_skip_t   sk  = isq_pkg::ISQ_SK_NONE,
      input logic [7:0]           opd = 8'h00,
      input logic [2:0]           f   = 3'b000);
    mk = {k, op, sk, f, t, opd};
  endfunction

  task automatic put(input int a, input isq_pkg::isq_cmd_t c);
    isq_fetch_model_inst.prog[a] = c;
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    avs_address_in   <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    // look mid-cycle so the edge's own updates cannot race the sample
    for (n = 0; n < 20; n++) begin
      @(negedge clk_in);
      if (avs_waitrequest_out === 1'b0) break;
      @(posedge clk_in);
    end
    if (avs_waitrequest_out !== 1'b0) bail("bus stuck");
    q = avs_readdata_out;
    @(posedge clk_in);
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge clk_in);
  endtask

  // reset held, program cleared; go releases it
  task automatic do_reset();
    arst_n_in <= 1'b0;
    int_raise <= 1'b0;
    for (int i = 0; i < 2048; i++) put(i, '0);
    repeat (3) @(posedge clk_in);
    check(32'(phase_out), 32'h1, "reset phase");
    check(32'(fetch_addr_out), 32'h0, "reset pc");
    trace.delete();
    n_ack = 0;
    n_ret = 0;
    n_we  = 0;
  endtask

  task automatic go();
    arst_n_in <= 1'b1;
    @(posedge clk_in);
  endtask

  task automatic wait_len(input int len);
    for (int n = 0; n < 400 && trace.size() < len; n++) @(posedge clk_in);
    if (trace.size() < len) bail("fetch stalled");
  endtask

  task automatic wait_addr(input logic [10:0] a);
    for (int n = 0; n < 200 && trace[$] !== a; n++) @(posedge clk_in);
    check(32'(trace[$]), 32'(a), "fetch target");
  endtask

  task automatic expect_trace(input logic [10:0] e[$]);
    wait_len(e.size());
    foreach (e[i]) check(32'(trace[i]), 32'(e[i]), "fetch order");
  endtask

  task automatic t_basic();
    logic [31:0] q;
    logic [3:0]  ph;
    do_reset();
    go();
    bus(1'b0, 4'h0, 8'h00, q);
    check(q, 32'h0, "pc low after reset");
    bus(1'b0, 4'h2, 8'h00, q);
    check(q, 32'h0, "unmapped read");
    avs_byteenable_in <= 4'h0;
    bus(1'b1, 4'h4, 8'h99, q);
    avs_byteenable_in <= 4'hf;
    bus(1'b0, 4'h4, 8'h00, q);
    check(q, 32'h0, "masked write");
    @(negedge clk_in);
    ph = phase_out;
    repeat (8) begin
      @(negedge clk_in);
      check(32'(phase_out), 32'({ph[2:0], ph[3]}), "ring");
      ph = phase_out;
    end
    @(posedge clk_in);
    bus(1'b1, 4'hc, 8'h00, q);
    ph = phase_out;
    repeat (8) @(posedge clk_in);
    check(32'(phase_out), 32'(ph), "frozen ring");
    bus(1'b1, 4'hc, 8'h01, q);
    expect_trace('{11'h000, 11'h001, 11'h002, 11'h003});
    $display("basic done");
  endtask

  task automatic t_branch();
    logic [31:0] q;
    do_reset();
    put(0, mk(isq_pkg::ISQ_K_JUMP, 11'h2f0));
    put('h2f0, mk(isq_pkg::ISQ_K_CALL, 11'h180));
    put('h180, mk(isq_pkg::ISQ_K_RET));
    go();
    expect_trace('{11'h000, 11'h001, 11'h2f0, 11'h2f1, 11'h180, 11'h181,
                   11'h2f1, 11'h2f2});
    bus(1'b1, 4'h0, 8'h55, q);
    wait_addr(11'h255);
    $display("branch done");
  endtask

  task automatic t_stack();
    logic [10:0] e[$];
    do_reset();
    for (int k = 0; k < 7; k++) begin
      put(k * 16, mk(isq_pkg::ISQ_K_CALL, 11'(k * 16 + 16)));
      e.push_back(11'(k * 16));
      e.push_back(11'(k * 16 + 1));
    end
    put('h70, mk(isq_pkg::ISQ_K_RET));
    e.push_back(11'h070);
    e.push_back(11'h071);
    for (int k = 6; k > 1; k--) begin
      put(k * 16 + 1, mk(isq_pkg::ISQ_K_RET));
      e.push_back(11'(k * 16 + 1));
      e.push_back(11'(k * 16 + 2));
    end
    put('h11, mk(isq_pkg::ISQ_K_JUMP, 11'h011));
    e.push_back(11'h011);
    e.push_back(11'h012);
    e.push_back(11'h011);
    go();
    expect_trace(e);
    $display("stack done");
  endtask

  task automatic t_int();
    int i;
    do_reset();
    for (int k = 0; k < 6; k++)
      put(k * 16, mk(isq_pkg::ISQ_K_CALL, 11'(k * 16 + 16)));
    put('h64, mk(isq_pkg::ISQ_K_RET));
    put(VEC, mk(isq_pkg::ISQ_K_RETURN_FROM_INTERRUPT));
    go();
    wait_addr(11'h060);
    int_raise <= 1'b1;
    @(posedge clk_in);
    int_raise <= 1'b0;
    wait_addr(11'h065);
    check(32'(n_ack), 32'h0, "ack on full stack");
    wait_addr(VEC);
    check(32'(n_ack), 32'h1, "one ack");
    i = trace.size() - 1;
    wait_len(i + 3);
    check(32'(trace[i + 2]), 32'(trace[i - 1]), "resume");
    check(32'(n_ret), 32'h1, "return pulse");
    $display("interrupt done");
  endtask

  // run two words from address zero with acc preset, then read back
  task automatic run2(input isq_pkg::isq_cmd_t c0, c1, input logic [7:0] a,
                      output logic [31:0] acc, st);
    logic [31:0] q;
    do_reset();
    put(0, c0);
    put(1, c1);
    go();
    bus(1'b1, 4'h4, a, q);
    wait_len(5);
    bus(1'b0, 4'h4, 8'h00, acc);
    bus(1'b0, 4'h8, 8'h00, st);
  endtask

  task automatic t_alu();
    logic [31:0] acc;
    logic [31:0] st;
    isq_pkg::isq_alu_op_t ops[5] = '{isq_pkg::ISQ_OP_ADD, isq_pkg::ISQ_OP_SUB,
      isq_pkg::ISQ_OP_AND, isq_pkg::ISQ_OP_OR, isq_pkg::ISQ_OP_XOR};
    logic [7:0] av[5] = '{8'hf0, 8'h5a, 8'hf0, 8'hf0, 8'hf0};
    logic [7:0] bv[5] = '{8'h20, 8'h5a, 8'h0f, 8'h0f, 8'hf0};
    logic [7:0] rv[5] = '{8'h10, 8'h00, 8'h00, 8'hff, 8'h00};
    logic [3:0] fv[5] = '{4'h1, 4'h7, 4'h4, 4'h0, 4'h4};
    for (int i = 0; i < 5; i++) begin
      run2(mk(isq_pkg::ISQ_K_ALU, 11'h000, ops[i], isq_pkg::ISQ_SK_NONE,
              bv[i], 3'b010), mk(isq_pkg::ISQ_K_NOP), av[i], acc, st);
      check(acc, 32'(rv[i]), "alu result");
      check(st, 32'(fv[i]), "alu flags");
    end
    run2(mk(isq_pkg::ISQ_K_ALU, 11'h000, isq_pkg::ISQ_OP_ADD,
            isq_pkg::ISQ_SK_NONE, 8'h20, 3'b011), mk(isq_pkg::ISQ_K_NOP),
         8'hf0, acc, st);
    check(acc, 32'hf0, "acc kept");
    check(32'(n_we), 32'h1, "memory write");
    check(32'(last_wd), 32'h10, "memory data");
    run2(mk(isq_pkg::ISQ_K_ALU, 11'h000, isq_pkg::ISQ_OP_PASS,
            isq_pkg::ISQ_SK_ZERO), mk(isq_pkg::ISQ_K_ALU, 11'h000,
         isq_pkg::ISQ_OP_PASS, isq_pkg::ISQ_SK_NONE, 8'h77, 3'b010),
         8'h00, acc, st);
    check(acc, 32'h0, "skipped word");
    run2(mk(isq_pkg::ISQ_K_ALU, 11'h000, isq_pkg::ISQ_OP_PASS,
            isq_pkg::ISQ_SK_NONZERO), mk(isq_pkg::ISQ_K_ALU, 11'h000,
         isq_pkg::ISQ_OP_PASS, isq_pkg::ISQ_SK_NONE, 8'h77, 3'b010),
         8'h00, acc, st);
    check(acc, 32'h77, "unskipped word");
    $display("alu done");
  endtask

  // main sequence
  initial begin
    t_basic();
    t_branch();
    t_stack();
    t_int();
    t_alu();
    end_of_test();
  end
endmodule
`default_nettype wire
